// ===== core/sac_params.svh
// Timing constants, widths and bus offsets for the converter control block.
// Assumes a 10 MHz system clock; included by the package, the shifter and the control block.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define SAC_CLK_PERIOD_NS   100
`define SAC_ACQ_START_NS    527
`define SAC_CONV_MAX_NS     1500
`define SAC_POR_WAIT_US     200
// Least time rounds up, longest time rounds down
`define SAC_ACQ_CYC   ((`SAC_ACQ_START_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_CONV_CYC  (`SAC_CONV_MAX_NS / `SAC_CLK_PERIOD_NS)
`define SAC_POR_CYC   ((`SAC_POR_WAIT_US * 1000) / `SAC_CLK_PERIOD_NS)

// ************************************************************
// Result and register map
// ************************************************************
`define SAC_RES_W           16
`define SAC_OFF_RESULT      4'h0
`define SAC_OFF_STATUS      4'h4
`define SAC_OFF_CONTROL     4'h8
`define SAC_CTRL_RST        32'h0000_0000
`define SAC_BAD_READ        32'hDEAD_BEEF

`endif

// ===== core/sac_pkg.sv
// Types shared by the converter control modules.
// Assumes sac_params.svh is on the include path.
package sac_pkg;
	`include "sac_params.svh"

	// Power and conversion state of the core
	typedef enum logic [2:0]
	{
		SAC_ST_NAP,
		SAC_ST_CONV,
		SAC_ST_SLEEP,
		SAC_ST_POR
	} sac_state_e;

	typedef logic [`SAC_RES_W-1:0] sac_word_t;
endpackage

// ===== core/sac_sync.sv
// Two-flop synchroniser with rise and fall detect on the settled copy.
// Assumes the input is asynchronous to mclk_i.
`timescale 1ns/100ps
module sac_sync
	import sac_pkg::*;
#(
	// Idle level of the pin; reset loads it so no false edge follows
	parameter logic RST_VAL = 1'b0
)
(
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// Pin and results
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;
	logic prev_reg;
	logic prev_next;

	// Next values; first stage feeds only the second
	always_comb
	begin
		meta_next = pin_i;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// Registers
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
			prev_reg <= RST_VAL;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign level_o = sync_reg;
	assign rise_o  = sync_reg & ~prev_reg;
	assign fall_o  = ~sync_reg & prev_reg;
endmodule

// ===== core/sac_shifter.sv
// Serial output shift register: load a result, shift on each link edge.
// Assumes load and shift are one-cycle pulses on mclk_i.
`timescale 1ns/100ps
`include "sac_params.svh"
module sac_shifter
	import sac_pkg::*;
#(
	parameter int WIDTH = `SAC_RES_W
)
(
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// Control
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic             shift_i,
	input  wire logic             serial_i,
	// Serial bit
	output logic                  bit_o
);
	logic [WIDTH-1:0] sh_reg;
	logic [WIDTH-1:0] sh_next;

	// Load wins over shift; the upstream bit follows the last result bit
	always_comb
	begin
		sh_next = sh_reg;
		if (load_i)
			sh_next = data_i;
		else if (shift_i)
			sh_next = {sh_reg[WIDTH-2:0], serial_i};
	end

	// Register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			sh_reg <= '0;
		else
			sh_reg <= sh_next;
	end

	assign bit_o = sh_reg[WIDTH-1];
endmodule

// ===== core/sac_adc_ctrl.sv
// Conversion timing, power states and serial readout of a 16-bit SAR core.
// Assumes a 10 MHz mclk_i, async pins synchronised here, Avalon-MM slave.
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "sac_params.svh"
module sac_adc_ctrl
	import sac_pkg::*;
#(
	parameter int POR_CYC = `SAC_POR_CYC
)
(
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// Host pins
	input  wire logic                  conversion_trigger_i,
	input  wire logic                  shift_clk_i,
	input  wire logic                  read_enable_or_serial_in_i,
	input  wire logic                  chain_select_i,
	input  wire logic                  supply_low_i,
	output logic                       busy_o,
	output logic                       serial_out_o,
	output logic                       serial_out_oe_o,
	// Core side
	input  wire logic [`SAC_RES_W-1:0] core_result_i,
	output logic                       core_power_o,
	output logic                       acquire_o,
	output logic                       asleep_o,
	output logic                       por_busy_o,
	// Avalon-MM slave
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest
);
	localparam int CONV_CYC = `SAC_CONV_CYC;
	localparam int ACQ_CYC  = `SAC_ACQ_CYC;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic trig_lvl;
	logic trig_rise;
	logic trig_fall;
	logic sck_rise;
	logic rden_lvl;
	logic rden_fall;
	logic chain_lvl;
	logic low_lvl;

	sac_sync u_trig (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.pin_i(conversion_trigger_i), .level_o(trig_lvl),
		.rise_o(trig_rise), .fall_o(trig_fall));
	sac_sync u_sck (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.pin_i(shift_clk_i), .level_o(),
		.rise_o(sck_rise), .fall_o());
	sac_sync #(.RST_VAL(1'b1)) u_rden (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.pin_i(read_enable_or_serial_in_i), .level_o(rden_lvl),
		.rise_o(), .fall_o(rden_fall));
	sac_sync u_chain (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.pin_i(chain_select_i), .level_o(chain_lvl),
		.rise_o(), .fall_o());
	sac_sync u_low (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.pin_i(supply_low_i), .level_o(low_lvl),
		.rise_o(), .fall_o());

	// ************************************************************
	// Conversion and power state
	// ************************************************************
	sac_state_e  st_reg;
	sac_state_e  st_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic [1:0]  tog_reg;
	logic [1:0]  tog_next;
	logic        sleep_req_reg;
	logic        sleep_req_next;
	sac_word_t   res_reg;
	sac_word_t   res_next;
	logic [15:0] conv_count_reg;
	logic [15:0] conv_count_next;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic        done;
	logic        trig_edge;

	assign trig_edge = trig_rise | trig_fall;

	// Next state: conversion timer, sleep request, power-on wait
	always_comb
	begin
		st_next         = st_reg;
		cnt_next        = cnt_reg;
		tog_next        = tog_reg;
		sleep_req_next  = sleep_req_reg;
		res_next        = res_reg;
		conv_count_next = conv_count_reg;
		done            = 1'b0;
		// count trigger toggles, shift edge clears
		if (sck_rise)
			tog_next = 2'h0;
		else if (trig_edge && tog_reg != 2'h2)
			tog_next = tog_reg + 2'h1;
		if (tog_next == 2'h2)
			sleep_req_next = 1'b1;
		if (low_lvl)
		begin
			st_next        = SAC_ST_POR;
			cnt_next       = '0;
			sleep_req_next = 1'b0;
			tog_next       = 2'h0;
		end
		else
		begin
			case (st_reg)
				SAC_ST_POR:
				begin
					// Trigger edges during reinit are dropped
					tog_next       = 2'h0;
					sleep_req_next = 1'b0;
					if (cnt_reg >= 32'(POR_CYC - 1))
					begin
						st_next  = SAC_ST_NAP;
						cnt_next = '0;
					end
					else
						cnt_next = cnt_reg + 32'h1;
				end
				SAC_ST_NAP:
				begin
					if (trig_rise)
					begin
						st_next  = SAC_ST_CONV;
						cnt_next = '0;
					end
				end
				SAC_ST_CONV:
				begin
					// fixed time inside the 1.5us limit
					if (cnt_reg >= 32'(CONV_CYC - 1))
					begin
						done            = 1'b1;
						res_next        = core_result_i;
						conv_count_next = conv_count_reg + 16'h1;
						cnt_next        = '0;
						if (sleep_req_next)
							st_next = SAC_ST_SLEEP;
						else
							st_next = SAC_ST_NAP;
						sleep_req_next = 1'b0;
						tog_next       = 2'h0;
					end
					else
						cnt_next = cnt_reg + 32'h1;
				end
				SAC_ST_SLEEP:
				begin
					if (sck_rise)
						st_next = SAC_ST_NAP;
				end
				default:
					st_next = SAC_ST_POR;
			endcase
		end
	end

	// Registers; power-on wait is also run after a reset release
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			st_reg         <= SAC_ST_POR;
			cnt_reg        <= '0;
			tog_reg        <= 2'h0;
			sleep_req_reg  <= 1'b0;
			res_reg        <= '0;
			conv_count_reg <= 16'h0;
		end
		else
		begin
			st_reg         <= st_next;
			cnt_reg        <= cnt_next;
			tog_reg        <= tog_next;
			sleep_req_reg  <= sleep_req_next;
			res_reg        <= res_next;
			conv_count_reg <= conv_count_next;
		end
	end

	assign busy_o       = (st_reg == SAC_ST_CONV);
	assign core_power_o = (st_reg == SAC_ST_CONV);
	assign acquire_o    = (st_reg == SAC_ST_NAP) ||
		((st_reg == SAC_ST_CONV) && (cnt_reg >= 32'(ACQ_CYC)));
	assign asleep_o     = (st_reg == SAC_ST_SLEEP);
	assign por_busy_o   = (st_reg == SAC_ST_POR);

	// ************************************************************
	// Serial readout
	// ************************************************************
	logic      load;
	logic      shift;
	logic      sdo_bit;
	logic      oe_reg;
	logic      oe_next;
	logic      sdo_reg;
	logic      sdo_next;

	// load at busy fall; in normal mode reload on read enable fall when not busy
	assign load  = done | (!chain_lvl && rden_fall && !busy_o);
	assign shift = sck_rise && (st_reg != SAC_ST_POR);

	// MSB first; capture upstream bit each edge
	// upstream bits follow the result with no gap
	sac_shifter #(.WIDTH(`SAC_RES_W)) u_shift (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.load_i  (load),
		.data_i  (res_next),
		.shift_i (shift),
		.serial_i(chain_lvl & rden_lvl),
		.bit_o   (sdo_bit)
	);

	// normal mode drives only with read enable low
	// chain mode keeps the output enabled
	always_comb
	begin
		oe_next  = chain_lvl | ~rden_lvl;
		// MSB held until the first shift edge
		sdo_next = sdo_bit;
	end

	// Output flops; data bit one cycle after the shifter, enable one cycle after the read enable sync
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			oe_reg  <= 1'b0;
			sdo_reg <= 1'b0;
		end
		else
		begin
			oe_reg  <= oe_next;
			sdo_reg <= sdo_next;
		end
	end

	assign serial_out_o    = sdo_reg;
	assign serial_out_oe_o = oe_reg;

	// ************************************************************
	// Avalon-MM registers
	// ************************************************************
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        ack_reg;
	logic        ack_next;
	logic        req;

	assign req = (avs_read | avs_write) & ~ack_reg;

	// One wait state: answer on the cycle after the request
	always_comb
	begin
		ack_next   = req;
		rdata_next = rdata_reg;
		ctrl_next  = ctrl_reg;
		if (req && avs_read)
		begin
			case (avs_address)
				`SAC_OFF_RESULT:
					rdata_next = {16'h0, res_reg};
				`SAC_OFF_STATUS:
					rdata_next = {conv_count_reg, 11'h0, chain_lvl,
						asleep_o, por_busy_o, sleep_req_reg, busy_o};
				`SAC_OFF_CONTROL:
					rdata_next = ctrl_reg;
				default:
					rdata_next = `SAC_BAD_READ;
			endcase
		end
		// Scratch word for software only; lands on the answering edge
		if (avs_write && ack_reg && avs_address == `SAC_OFF_CONTROL)
			ctrl_next = avs_writedata;
	end

	// Bus registers
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			rdata_reg <= 32'h0;
			ack_reg   <= 1'b0;
			ctrl_reg  <= `SAC_CTRL_RST;
		end
		else
		begin
			rdata_reg <= rdata_next;
			ack_reg   <= ack_next;
			ctrl_reg  <= ctrl_next;
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
endmodule

// ===== test/sac_host_model.sv
// Host model: drives trigger, shift clock and read enable or serial in.
// Assumes mclk_i at 10 MHz; shift clock of 800 ns, low outside frames.
`timescale 1ns/100ps
module sac_host_model
(
	// Clock and device pins
	input  wire logic mclk_i,
	input  wire logic busy_i,
	input  wire logic sdo_i,
	// Host pins
	output logic      cnv_o,
	output logic      sck_o,
	output logic      rdl_o
);
	// ****************
	// Host tasks
	// ****************
	// idle deselected
	initial
	begin
		cnv_o = 1'b0;
		sck_o = 1'b0;
		rdl_o = 1'b1;
	end

	task automatic convert();
		cnv_o <= 1'b1;
		do
			@(posedge mclk_i);
		while (busy_i !== 1'b1);
		do
			@(posedge mclk_i);
		while (busy_i !== 1'b0);
		cnv_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic frame(input int n, input logic [31:0] up,
		input logic idle, output logic [31:0] w);
		w = '0;
		rdl_o <= up[31];
		repeat (4) @(posedge mclk_i);
		for (int i = 0; i < n; i++)
		begin
			w = {w[30:0], sdo_i};
			sck_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			sck_o <= 1'b0;
			if (i < 31)
				rdl_o <= up[30-i];
			repeat (4) @(posedge mclk_i);
		end
		rdl_o <= idle;
		@(posedge mclk_i);
	endtask
endmodule

// ===== test/sac_adc_ctrl_chk.sv
// Checker for the converter control block's pin behaviour.
// Assumes binding to sac_adc_ctrl with conversion of 15 cycles.
`timescale 1ns/100ps
module sac_adc_ctrl_chk
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Watched pins
	input wire logic shift_clk_i,
	input wire logic read_enable_or_serial_in_i,
	input wire logic chain_select_i,
	input wire logic supply_low_i,
	input wire logic busy_o,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_o,
	input wire logic core_power_o,
	input wire logic acquire_o,
	input wire logic asleep_o,
	input wire logic por_busy_o
);
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	busy_len_a: assert property ($rose(busy_o) |-> busy_o[*8] ##1
		busy_o[*7] ##1 !busy_o) else $error("busy length wrong");
	core_pwr_a: assert property (busy_o == core_power_o)
		else $error("core power wrong");
	acq_start_a: assert property ($rose(busy_o) |->
		!acquire_o[*6] ##1 acquire_o)
		else $error("acquire late");
	restart_gap_a: assert property ($fell(busy_o) |-> !busy_o[*3])
		else $error("restart too soon");
	oe_norm_a: assert property ((!chain_select_i &&
		read_enable_or_serial_in_i)[*5] |-> !serial_out_oe_o)
		else $error("output driven while deselected");
	oe_chain_a: assert property ((chain_select_i && !por_busy_o)[*5]
		|-> serial_out_oe_o) else $error("chain output off");
	por_entry_a: assert property (supply_low_i[*4] |-> por_busy_o &&
		!busy_o) else $error("no reset wait");
	wake_up_a: assert property (asleep_o && $rose(shift_clk_i)
		|-> ##[1:5] !asleep_o) else $error("no wake");
	msb_hold_a: assert property (($stable(shift_clk_i) && !busy_o &&
		$stable(read_enable_or_serial_in_i) && $stable(chain_select_i) &&
		!por_busy_o)[*6] |-> $stable(serial_out_o))
		else $error("serial bit moved");
endmodule

bind sac_adc_ctrl sac_adc_ctrl_chk chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.shift_clk_i(shift_clk_i), .chain_select_i(chain_select_i),
	.read_enable_or_serial_in_i(read_enable_or_serial_in_i),
	.supply_low_i(supply_low_i), .busy_o(busy_o), .serial_out_o(serial_out_o),
	.serial_out_oe_o(serial_out_oe_o), .core_power_o(core_power_o),
	.acquire_o(acquire_o), .asleep_o(asleep_o), .por_busy_o(por_busy_o));

// ===== test/sac_adc_ctrl_test.sv
// Bench for the converter control block: host model, bus master, queue.
// Assumes design, package, host model and checker compiled before it.
`timescale 1ns/100ps
module sac_adc_ctrl_test;
	import sac_pkg::*;
	// ****************
	// Signals
	// ****************
	localparam int WAKE_T = 10;
	logic        mclk_i, rst_n_i, chain_select_i, supply_low_i;
	logic        conversion_trigger, sck, rdl, busy_o, sdo, oe, por_busy_o;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, got_v, w, r;
	logic [63:0] e;
	logic [63:0] q[$];
	logic [15:0] res;
	int          n_fail, cmp_count, seed;
	event        got_e;
	// Released line shows the inverse, never a stale bit
	wire sdo_w = oe ? sdo : ~sdo;

	sac_adc_ctrl #(.POR_CYC(20)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.conversion_trigger_i(conversion_trigger), .shift_clk_i(sck),
		.read_enable_or_serial_in_i(rdl), .chain_select_i(chain_select_i),
		.supply_low_i(supply_low_i), .busy_o(busy_o), .serial_out_o(sdo),
		.serial_out_oe_o(oe), .core_result_i(res), .core_power_o(),
		.acquire_o(), .asleep_o(), .por_busy_o(por_busy_o),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	sac_host_model host_u (.mclk_i(mclk_i), .busy_i(busy_o), .sdo_i(sdo_w),
		.cnv_o(conversion_trigger), .sck_o(sck), .rdl_o(rdl));

	// ****************
	// Tasks
	// ****************
	task automatic got(input logic [31:0] v);
		got_v = v;
		-> got_e;
	endtask

	// Read takes d as expected value under mask m
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [31:0] m);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do
			@(posedge mclk_i);
		while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (!wr)
		begin
			q.push_back({m, d});
			got(avs_readdata);
		end
		@(posedge mclk_i);
	endtask

	// One conversion of a random result, then a frame of n bits
	task automatic conv_read(input int n, input logic [15:0] up,
		input logic idle);
		res <= 16'($random(seed));
		@(posedge mclk_i);
		host_u.convert();
		q.push_back(n == 16 ? {32'hFFFF, 16'h0, res} : {32'hFFFFFFFF, res, up});
		host_u.frame(n, {up, 16'h0}, idle, w);
		got(w);
	endtask

	task automatic por_wait();
		while (por_busy_o !== 1'b0)
			@(posedge mclk_i);
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ****************
	// Processes
	// ****************
	// Oldest note meets each result
	always @(got_e)
	begin
		e = q.pop_front();
		cmp_count++;
		if ((got_v & e[63:32]) !== (e[31:0] & e[63:32]))
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, e[31:0]);
		end
	end

	// Clock
	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#3000000;
		n_fail++;
		results();
	end

	// Main sequence
	initial
	begin
		{rst_n_i, chain_select_i, supply_low_i, avs_read, avs_write} = '0;
		{avs_address, avs_writedata, res, n_fail, cmp_count} = '0;
		seed = 32'h6e6b;
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		r = $random(seed);
		bus(1'b0, 4'h4, 32'h4, 32'h4);
		bus(1'b0, 4'h8, 32'h0, 32'hFFFFFFFF);
		bus(1'b1, 4'h8, r, 32'h0);
		bus(1'b0, 4'h8, r, 32'hFFFFFFFF);
		bus(1'b0, 4'hC, 32'hDEADBEEF, 32'hFFFFFFFF);
		por_wait();
		$display("test regs done");
		for (int i = 0; i < 3; i++)
		begin
			conv_read(16, 16'h0, i == 2);
			bus(1'b0, 4'h0, {16'h0, res}, 32'hFFFF);
		end
		bus(1'b0, 4'h4, 32'h0003_0000, 32'hFFFF_0001);
		$display("test normal done");
		chain_select_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		conv_read(32, 16'($random(seed)), 1'b0);
		conv_read(32, 16'($random(seed)), 1'b0);
		chain_select_i <= 1'b0;
		$display("test chain done");
		host_u.convert();
		host_u.convert();
		bus(1'b0, 4'h4, 32'h8, 32'h8);
		host_u.frame(1, 32'h0, 1'b1, w);
		bus(1'b0, 4'h4, 32'h0, 32'h8);
		repeat (WAKE_T) @(posedge mclk_i);
		conv_read(16, 16'h0, 1'b1);
		$display("test sleep done");
		supply_low_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		bus(1'b0, 4'h4, 32'h4, 32'h4);
		supply_low_i <= 1'b0;
		por_wait();
		conv_read(16, 16'h0, 1'b1);
		$display("test supply done");
		results();
	end
endmodule
